// ===== src/ivm_consts.vh
// Purpose: Constants for the interrupt vector map block
// Assumes: APB register offsets are byte addresses, one word each
// Notes: Vector offsets are byte offsets from the relocatable base
`ifndef IVM_CONSTS_VH
`define IVM_CONSTS_VH
// Register byte offsets
`define IVM_OFF_BASE 12'h000
`define IVM_OFF_CTRL 12'h004
`define IVM_OFF_STAT 12'h008
`define IVM_OFF_MASK 12'h00C
`define IVM_OFF_VEC 12'h010
`define IVM_OFF_PEND 12'h014
// Reset values
`define IVM_BASE_RST 8'hFF
`define IVM_CTRL_RST 7'h00
// Control register field positions
`define IVM_CTRL_OVF 0
`define IVM_CTRL_EDGE 1
`define IVM_CTRL_TXE 2
`define IVM_CTRL_TXC 3
`define IVM_CTRL_RXF 4
`define IVM_CTRL_IDLE 5
`define IVM_CTRL_PER 6
// Source vector offsets, lowest byte of the 16-bit vector address
`define IVM_VOFF_TRAP 8'hF8
`define IVM_VOFF_OVF 8'hDC
`define IVM_VOFF_EDGE 8'hDA
`define IVM_VOFF_SER 8'hD6
`define IVM_VOFF_PER 8'h88
`define IVM_VOFF_SPUR 8'h80
// Status bit positions, also source index in priority order
`define IVM_SRC_OVF 3
`define IVM_SRC_EDGE 2
`define IVM_SRC_SER 1
`define IVM_SRC_PER 0
`define IVM_NSRC 4
`endif

// ===== src/ivm_sync.v
// Purpose: Three-stage synchroniser with second/third agreement
// Assumes: Input is asynchronous to ref_clk
// Notes: Stage one feeds only stage two
`timescale 1ns/1ns
`default_nettype none
module ivm_sync (
  input wire ref_clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire din, // Raw input
  output reg dout // Filtered level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  // Shift chain; output moves only when stages two and three agree
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule // ivm_sync
`default_nettype wire

// ===== src/ivm_vector_map.v
// What this block does
// - Higher vector offset wins priority, trap highest
// - Vector equals programmable base plus offset
// - Overflow at DC, I-masked, wakes wait only
// - Edge at DA, I-masked, wakes wait only
// - Serial at D6, four enables, wakes both
// - Periodic at 88, I-masked, wakes both
//
// Purpose: Vector mapping, priority and wakeup for four sources plus trap
// Assumes: Core raises vecFetch one cycle; APB slave has zero wait states
// Notes: Source requests are pins, so they are synchronised first
`timescale 1ns/1ns
`default_nettype none
`include "ivm_consts.vh"
module ivm_vector_map (
  input wire ref_clk, // 25 MHz system clock
  input wire rst_n, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire accumOverflowReq, // Pulse accumulator overflow request
  input wire accumEdgeReq, // Pulse accumulator edge request
  input wire serialTxEmptyReq, // Serial transmit empty
  input wire serialTxCompleteReq, // Serial transmit complete
  input wire serialRxFullReq, // Serial receive full
  input wire serialIdleReq, // Serial idle line
  input wire periodicReq, // Periodic wakeup request
  input wire trapReq, // Unimplemented instruction trap, core side
  input wire ccrIBit, // Core I mask bit, 1 masks
  input wire stopMode, // Chip is in stop
  input wire waitMode, // Chip is in wait
  input wire vecFetch, // Core fetches a vector this cycle
  output reg irqReq, // Request to core
  output reg [15:0] vecAddr, // Vector address answer
  output reg vecValid, // Vector answer strobe
  output reg wakeReq, // Wake from stop or wait
  output reg irqOut // Status/mask level interrupt
);
  wire ovfS;
  wire edgeS;
  wire txeS;
  wire txcS;
  wire rxfS;
  wire idleS;
  wire perS;
  reg [7:0] base_ff;
  reg [6:0] ctrl_ff;
  reg [3:0] stat_ff;
  reg [3:0] mask_ff;
  reg [15:0] lastVec_ff;
  reg [3:0] evtPrev_ff;
  reg [3:0] srcRaw;
  reg [3:0] srcEn;
  reg [3:0] live;
  reg [7:0] winOff;
  reg anyLive;
  reg [3:0] nxt_stat;
  reg [31:0] rdMux;
  reg rdHit;
  reg wakeNow;
  wire wrAcc;
  wire acc;

  // Pins cross into ref_clk through three stages
  ivm_sync uOvf (.ref_clk(ref_clk), .rst_n(rst_n), .din(accumOverflowReq), .dout(ovfS));
  ivm_sync uEdge (.ref_clk(ref_clk), .rst_n(rst_n), .din(accumEdgeReq), .dout(edgeS));
  ivm_sync uTxe (.ref_clk(ref_clk), .rst_n(rst_n), .din(serialTxEmptyReq), .dout(txeS));
  ivm_sync uTxc (.ref_clk(ref_clk), .rst_n(rst_n), .din(serialTxCompleteReq), .dout(txcS));
  ivm_sync uRxf (.ref_clk(ref_clk), .rst_n(rst_n), .din(serialRxFullReq), .dout(rxfS));
  ivm_sync uIdle (.ref_clk(ref_clk), .rst_n(rst_n), .din(serialIdleReq), .dout(idleS));
  ivm_sync uPer (.ref_clk(ref_clk), .rst_n(rst_n), .din(periodicReq), .dout(perS));

  // Local enable gating of each source
  always @* begin
    srcRaw = 4'h0;
    srcEn = 4'h0;
    srcRaw[`IVM_SRC_OVF] = ovfS;
    srcEn[`IVM_SRC_OVF] = ctrl_ff[`IVM_CTRL_OVF];
    srcRaw[`IVM_SRC_EDGE] = edgeS;
    srcEn[`IVM_SRC_EDGE] = ctrl_ff[`IVM_CTRL_EDGE];
    srcRaw[`IVM_SRC_SER] = (txeS & ctrl_ff[`IVM_CTRL_TXE]) | (txcS & ctrl_ff[`IVM_CTRL_TXC])
                         | (rxfS & ctrl_ff[`IVM_CTRL_RXF]) | (idleS & ctrl_ff[`IVM_CTRL_IDLE]);
    srcEn[`IVM_SRC_SER] = 1'b1;
    srcRaw[`IVM_SRC_PER] = perS;
    srcEn[`IVM_SRC_PER] = ctrl_ff[`IVM_CTRL_PER];
    // I bit masks every maskable source
    live = (ccrIBit) ? 4'h0 : (srcRaw & srcEn);
  end

  // Priority pick; order follows descending offset
  always @* begin
    anyLive = 1'b1;
    if (trapReq) begin
      winOff = `IVM_VOFF_TRAP;
    end else if (live[`IVM_SRC_OVF]) begin
      winOff = `IVM_VOFF_OVF;
    end else if (live[`IVM_SRC_EDGE]) begin
      winOff = `IVM_VOFF_EDGE;
    end else if (live[`IVM_SRC_SER]) begin
      winOff = `IVM_VOFF_SER;
    end else if (live[`IVM_SRC_PER]) begin
      winOff = `IVM_VOFF_PER;
    end else begin
      winOff = `IVM_VOFF_SPUR;
      anyLive = 1'b0;
    end
  end

  // Wakeup: stop only for serial and periodic, wait for all
  always @* begin
    wakeNow = 1'b0;
    if (waitMode && (live != 4'h0)) begin
      wakeNow = 1'b1;
    end
    if (stopMode && (live[`IVM_SRC_SER] || live[`IVM_SRC_PER])) begin
      wakeNow = 1'b1;
    end
  end

  assign acc = psel & penable;
  assign wrAcc = acc & pwrite;

  // Sticky status: rising request sets, write-one clears, set wins
  always @* begin
    nxt_stat = stat_ff;
    if (wrAcc && paddr == `IVM_OFF_STAT) begin
      nxt_stat = stat_ff & ~pwdata[3:0];
    end
    nxt_stat = nxt_stat | (srcRaw & ~evtPrev_ff);
  end

  // Register read mux
  always @* begin
    rdHit = 1'b1;
    case (paddr)
      `IVM_OFF_BASE: rdMux = {24'h0000_00, base_ff};
      `IVM_OFF_CTRL: rdMux = {25'h000_0000, ctrl_ff};
      `IVM_OFF_STAT: rdMux = {28'h000_0000, stat_ff};
      `IVM_OFF_MASK: rdMux = {28'h000_0000, mask_ff};
      `IVM_OFF_VEC: rdMux = {16'h0000, lastVec_ff};
      `IVM_OFF_PEND: rdMux = {28'h000_0000, live};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  // APB slave, answers in the access cycle with no waits
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= `IVM_BASE_RST;
      ctrl_ff <= `IVM_CTRL_RST;
      mask_ff <= 4'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rdHit;
      prdata <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0000_0000;
      if (wrAcc && pready) begin
        case (paddr)
          `IVM_OFF_BASE: base_ff <= pwdata[7:0];
          `IVM_OFF_CTRL: ctrl_ff <= pwdata[6:0];
          `IVM_OFF_MASK: mask_ff <= pwdata[3:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // Status, edge history, interrupt line
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= 4'h0;
      evtPrev_ff <= 4'h0;
      irqOut <= 1'b0;
    end else begin
      stat_ff <= (acc && pready) ? nxt_stat : (stat_ff | (srcRaw & ~evtPrev_ff));
      evtPrev_ff <= srcRaw;
      irqOut <= |(nxt_stat & mask_ff);
    end
  end

  // Core-facing request and vector answer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq <= 1'b0;
      vecAddr <= 16'h0000;
      vecValid <= 1'b0;
      wakeReq <= 1'b0;
      lastVec_ff <= 16'h0000;
    end else begin
      irqReq <= anyLive;
      wakeReq <= wakeNow;
      vecValid <= vecFetch;
      if (vecFetch) begin
        // Base high byte plus even slot offset
        vecAddr <= {base_ff, winOff};
        lastVec_ff <= {base_ff, winOff};
      end
    end
  end
endmodule // ivm_vector_map
`default_nettype wire

// ===== test/ivm_core_model.sv
// Purpose: Core side that fetches vectors
// Assumes: Go is a one-cycle pulse
// Notes: Lag gives prompt or slow fetches
`timescale 1ns/1ns
`default_nettype none
module ivm_core_model (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic go, // Start a fetch
  input wire logic [1:0] lag, // Extra delay
  output logic vecFetch // One-cycle fetch
);
  logic [2:0] cnt_ff;
  // Fetch pulse when the delay runs out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 3'h0;
      vecFetch <= 1'b0;
    end else begin
      vecFetch <= (cnt_ff == 3'h1);
      cnt_ff <= go ? {1'b0, lag} + 3'h1 : cnt_ff - {2'b0, cnt_ff != 3'h0};
    end
  end
endmodule // ivm_core_model
`default_nettype wire

// ===== test/ivm_vector_map_props.sv
// Purpose: Port checks for the vector map
// Assumes: One clock domain
// Notes: Bound to every map instance
`timescale 1ns/1ns
`default_nettype none
module ivm_vector_map_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic trapReq, // Trap
  input wire logic ccrIBit, // I mask
  input wire logic vecFetch, // Fetch
  input wire logic vecValid, // Strobe
  input wire logic [15:0] vecAddr, // Vector
  input wire logic irqReq, // Request to core
  input wire logic wakeReq // Wake
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_fetch_answer: assert property (vecFetch |=> vecValid) else $error("no answer");
  a_valid_cause: assert property (vecValid |-> $past(vecFetch)) else $error("stray");
  a_slot_even: assert property (vecValid |-> !vecAddr[0]) else $error("odd slot");
  a_addr_holds: assert property (!vecValid |-> $stable(vecAddr)) else $error("moved");
  a_trap_top: assert property (vecFetch && trapReq |=> vecAddr[7:0] == 8'hF8) else $error("trap");
  a_ibit_nowake: assert property (ccrIBit [*2] |=> !wakeReq) else $error("wake");
  // Trap is never masked, so it always raises the request
  a_trap_req: assert property (trapReq |=> irqReq) else $error("trap request");
  a_ibit_noreq: assert property (ccrIBit && !trapReq |=> !irqReq) else $error("masked request");
  // Zero wait states, so ready follows setup at once
  a_ready_next: assert property (psel && !penable |=> pready) else $error("ready");
  a_err_ready: assert property (pslverr |-> pready && psel) else $error("error");
endmodule // ivm_vector_map_chk
bind ivm_vector_map ivm_vector_map_chk u_chk (.ref_clk, .rst_n, .psel, .penable, .pready,
  .pslverr, .trapReq, .ccrIBit, .vecFetch, .vecValid, .vecAddr, .irqReq, .wakeReq);
`default_nettype wire

// ===== test/tb.sv
// Purpose: Bench for the vector map
// Assumes: Source sync settles in six cycles
// Notes: Core model makes the fetches
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic trap = 0, ib = 0, stp = 0, wt = 0, err;
  logic [3:0] src = 0, ser = 0;
  logic [1:0] lag = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q, v;
  logic [7:0] tbl [5] = '{8'hDC, 8'hDA, 8'hD6, 8'h88, 8'h80};
  wire [31:0] prdata;
  wire [15:0] vecAddr;
  wire pready, pslverr, irqReq, vecValid, wakeReq, irqOut, vecFetch;
  int nFail = 0, samplesChecked = 0, i, k;
  always #20 ref_clk = ~ref_clk;
  ivm_vector_map uut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .accumOverflowReq(src[3]), .accumEdgeReq(src[2]),
    .serialTxEmptyReq(ser[0]), .serialTxCompleteReq(ser[1]), .serialRxFullReq(ser[2]),
    .serialIdleReq(ser[3]), .periodicReq(src[0]), .trapReq(trap), .ccrIBit(ib),
    .stopMode(stp), .waitMode(wt), .vecFetch, .irqReq, .vecAddr, .vecValid, .wakeReq, .irqOut);
  ivm_core_model core (.ref_clk, .rst_n, .go, .lag, .vecFetch);
  task conclude;
    $display("checked %0d wrong %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    samplesChecked++;
    if (g !== e) begin
      nFail++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  // A used-up wait ends the run
  task tmo;
    if (k == 20) begin
      nFail++;
      conclude;
    end
  endtask
  // Setup, then access held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge ref_clk);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    tmo;
  endtask
  task fetch(input logic [15:0] e);
    go <= 1;
    @(posedge ref_clk);
    go <= 0;
    for (k = 0; k < 20 && vecValid !== 1'b1; k++) @(posedge ref_clk);
    tmo;
    chk(vecAddr, e);
  endtask
  // Sources pass a synchroniser first
  task settle;
    repeat (6) @(posedge ref_clk);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    apb(0, 12'h000, 0);
    chk(q, 32'h0000_00FF);
    apb(0, 12'h018, 0);
    chk(err, 1);
    apb(1, 12'h000, 32'h0000_0040);
    apb(1, 12'h004, 32'h0000_007F);
    apb(1, 12'h00C, 32'h0000_000F);
    src <= 4'hD;
    ser <= 4'h1;
    trap <= 1;
    settle;
    chk(irqOut, 1);
    chk(irqReq, 1);
    fetch(16'h40F8);
    trap <= 0;
    // Drop the winner each round, spurious last
    for (i = 0; i < 5; i++) begin
      fetch({8'h40, tbl[i]});
      src <= src & ~(4'h8 >> i);
      if (i == 2) ser <= 0;
      settle;
    end
    apb(1, 12'h008, 32'h0000_000F);
    apb(0, 12'h008, 0);
    chk(q, 0);
    chk(irqOut, 0);
    // Last vector register keeps the spurious answer
    apb(0, 12'h010, 0);
    chk(q, 32'h0000_4080);
    $display("test priority done");
    src <= 4'h1;
    stp <= 1;
    settle;
    chk(wakeReq, 1);
    src <= 4'h8;
    settle;
    chk(wakeReq, 0);
    src <= 4'h4;
    settle;
    chk(wakeReq, 0);
    stp <= 0;
    wt <= 1;
    settle;
    chk(wakeReq, 1);
    src <= 4'h8;
    settle;
    chk(wakeReq, 1);
    src <= 4'h4;
    ib <= 1;
    settle;
    chk(wakeReq, 0);
    chk(irqReq, 0);
    fetch(16'h4080);
    ib <= 0;
    apb(1, 12'h004, 32'h0000_007D);
    settle;
    fetch(16'h4080);
    $display("test wake done");
    src <= 0;
    stp <= 1;
    // Stop alone, so a wait wake cannot hide a missing stop wake
    wt <= 0;
    // Each serial enable alone, slower fetch each time
    for (i = 0; i < 4; i++) begin
      apb(1, 12'h004, 32'h0000_0004 << i);
      ser <= 4'h1 << i;
      lag <= i[1:0];
      settle;
      chk(wakeReq, 1);
      fetch(16'h40D6);
      ser <= 0;
    end
    $display("test serial done");
    conclude;
  end
endmodule // tb
`default_nettype wire
